// ---- common/vis_pkg.sv ----
// Constants, carriers and decode helpers for the video input selector register bank.
package vis_pkg;

	// -------------------------------------------------------------------
	// Register map.
	// -------------------------------------------------------------------
	localparam logic [4:0] ADDR_CONTROL     = 5'h00;
	localparam logic [4:0] ADDR_RESERVED    = 5'h01;
	localparam logic [7:0] CTRL_RESET       = 8'h00;
	localparam logic [7:0] RESERVED_READ    = 8'h00;
	localparam int         SEL_W            = 3;
	localparam int         FIRST_SEL_LSB    = 0;
	localparam int         SECOND_SEL_LSB   = 4;
	localparam logic [2:0] SEL_OFF          = 3'h0;
	localparam int         INPUT_COUNT      = 7;

	// -------------------------------------------------------------------
	// Three-wire frame and timing.
	// -------------------------------------------------------------------
	localparam int         FRAME_BITS       = 16;
	localparam logic       WRITE_BIT        = 1'b1;
	localparam int         CLK_SYS_KHZ      = 125000;
	localparam int         SCLK_MAX_KHZ     = 5000;
	localparam int         SCLK_PERIOD_CYC  = (CLK_SYS_KHZ + SCLK_MAX_KHZ - 1) / SCLK_MAX_KHZ;
	localparam int         SAMPLES_MIN      = 4;

	// Serial frame as shifted in, most significant field first.
	typedef struct packed {
		logic [1:0] chip_addr;
		logic       write_bit;
		logic [4:0] reg_addr;
		logic [7:0] data;
	} vis_frame_type;

	// Stored control fields.
	typedef struct packed {
		logic [2:0] second_sel;
		logic [2:0] first_sel;
	} vis_ctrl_type;

	typedef enum logic [1:0] {
		VIS_IDLE,
		VIS_SHIFT,
		VIS_WAIT_DESELECT
	} vis_state_type;

	// Turns a selection code into one enable per input; code zero enables none.
	function automatic logic [INPUT_COUNT-1:0] vis_input_enables(input logic [2:0] code);
		logic [INPUT_COUNT-1:0] en;
		en = '0;
		if (code != SEL_OFF) begin
			en[code - 3'h1] = 1'b1;
		end
		return en;
	endfunction

	// Packs the control fields into the register image, fixed bits as zero.
	function automatic logic [7:0] vis_ctrl_image(input vis_ctrl_type c);
		return {1'b0, c.second_sel, 1'b0, c.first_sel};
	endfunction

endpackage

// ---- dv/vis_host.sv ----
// Host model that shifts three-wire write frames into the register bank.
`timescale 1ns/1ns
module vis_host
	import vis_pkg::*;
(
	// Clock that paces the host.
	input  wire logic clk_sys,
	// Three-wire lines toward the device.
	output logic      serial_select_n,
	output logic      serial_shift_clock,
	output logic      serial_data_input
);
	// Lines idle deselected, with the shift clock standing low.
	initial begin
		serial_select_n    = 1'h1;
		serial_shift_clock = 1'h0;
		serial_data_input  = 1'h0;
	end

	// Sends the first nbits of one frame MSB first; every level stands for half clock cycles.
	task automatic send(input vis_frame_type f, input int half, input int nbits);
		logic [15:0] b;
		b = f;
		@(posedge clk_sys);
		serial_select_n <= 1'h0;
		repeat (half) @(posedge clk_sys);
		for (int i = 15; i >= 16 - nbits; i--) begin
			serial_data_input <= b[i];
			repeat (half) @(posedge clk_sys);
			serial_shift_clock <= 1'h1;
			repeat (half) @(posedge clk_sys);
			serial_shift_clock <= 1'h0;
		end
		repeat (half) @(posedge clk_sys);
		// Select rises between frames; the released data line is driven to the inverse of frame bit 0.
		serial_select_n <= 1'h1;
		serial_data_input <= ~b[0];
		repeat (half) @(posedge clk_sys);
	endtask
endmodule

// ---- dv/vis_regs_test.sv ----
// Self-checking testbench of the video input selector register bank.
`timescale 1ns/1ns
module vis_regs_test
	import vis_pkg::*;
;
	logic       clk_sys, rst, power_down_reset_pin_n;
	wire logic  serial_select_n, serial_shift_clock, serial_data_input;
	logic [1:0] strap;
	logic [4:0] read_addr;
	logic [7:0] read_data;
	logic [2:0] first_output_select, second_output_select, e1, e2, s2;
	logic [6:0] video_out_first_enable, video_out_second_enable;
	logic       write_accepted;
	int         n_fail = 0, checks = 0, n_acc = 0;

	vis_host u_host (.clk_sys(clk_sys), .serial_select_n(serial_select_n),
		.serial_shift_clock(serial_shift_clock), .serial_data_input(serial_data_input));
	vis_regs u_vis_regs (.clk_sys(clk_sys), .rst(rst),
		.power_down_reset_pin_n(power_down_reset_pin_n), .serial_select_n(serial_select_n),
		.serial_shift_clock(serial_shift_clock), .serial_data_input(serial_data_input),
		.chip_addr_bit_low(strap[0]), .chip_addr_bit_high(strap[1]), .read_addr(read_addr),
		.read_data(read_data), .first_output_select(first_output_select),
		.second_output_select(second_output_select),
		.video_out_first_enable(video_out_first_enable),
		.video_out_second_enable(video_out_second_enable), .write_accepted(write_accepted));

	// Clock toggles every half period and accepted writes are counted.
	always #4 clk_sys = ~clk_sys;
	always @(posedge clk_sys) if (write_accepted === 1'h1) n_acc++;

	// Expected one-hot input enables of a selection code.
	function automatic logic [6:0] exp_en(input logic [2:0] c);
		return (c == 3'h0) ? 7'h00 : 7'(7'h01 << (c - 3'h1));
	endfunction

	// Compares one value and counts the result.
	task automatic cmp(input logic [7:0] got, input logic [7:0] exp, input string what);
		checks++;
		if (got !== exp) begin
			n_fail++;
			$display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
		end
	endtask

	// Prints the counts and the verdict, then ends the run.
	task automatic finish_test();
		$display("checks %0d n_fail %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	// Checks selects, enables and the control read-back against e1 and e2, and the reserved read-back against zero.
	task automatic check_state();
		read_addr <= ADDR_CONTROL;
		repeat (3) @(posedge clk_sys);
		cmp({5'h00, first_output_select}, {5'h00, e1}, "first select");
		cmp({5'h00, second_output_select}, {5'h00, e2}, "second select");
		cmp({1'h0, video_out_first_enable}, {1'h0, exp_en(e1)}, "first enables");
		cmp({1'h0, video_out_second_enable}, {1'h0, exp_en(e2)}, "second enables");
		cmp(read_data, {1'h0, e2, 1'h0, e1}, "control image");
		read_addr <= ADDR_RESERVED;
		repeat (3) @(posedge clk_sys);
		cmp(read_data, RESERVED_READ, "reserved read");
	endtask

	// Sends a frame at a random pace and checks whether it was accepted.
	task automatic write(input logic [1:0] ca, input logic wb, input logic [4:0] ra,
		input logic [7:0] d, input bit ok);
		int n0, k;
		n0 = n_acc;
		u_host.send({ca, wb, ra, d}, 4 + int'($urandom % 17), FRAME_BITS);
		for (k = 0; ok && k < 100 && n_acc == n0; k++) @(posedge clk_sys);
		if (k == 100) begin
			n_fail++;
			$display("unexpected at %0t: write never accepted", $time);
			finish_test();
		end
		repeat (40) @(posedge clk_sys);
		cmp(8'(n_acc - n0), {7'h00, ok}, "accepted writes");
		if (ok) {e2, e1} = {d[6:4], d[2:0]};
	endtask

	// -------------------------------------------------------------------
	// Stimulus.
	// -------------------------------------------------------------------
	initial begin
		void'($urandom(12));
		{clk_sys, read_addr, e1, e2} = '0;
		power_down_reset_pin_n = 1'h1;
		// Reset rises after every process waits, so the bank clears before the first edge.
		rst <= 1'h1;
		strap = 2'($urandom);
		repeat (10) @(posedge clk_sys);
		rst <= 1'h0;
		repeat (4) @(posedge clk_sys);
		check_state();
		$display("reset test done");
		// Every code on the first output, random codes on the second; fixed bits zero.
		for (int i = 0; i < 8; i++) begin
			s2 = 3'($urandom);
			write(strap, WRITE_BIT, ADDR_CONTROL, {1'h0, s2, 1'h0, 3'(i)}, 1);
			check_state();
		end
		$display("select code test done");
		// Wrong chip address, read bit and reserved address are all ignored.
		write(~strap, WRITE_BIT, ADDR_CONTROL, 8'h77, 0);
		write(strap, 1'h0, ADDR_CONTROL, 8'h66, 0);
		write(strap, WRITE_BIT, ADDR_RESERVED, 8'h55, 0);
		check_state();
		$display("refused frame test done");
		// A frame cut short after fifteen bits is dropped when select rises.
		u_host.send({strap, WRITE_BIT, ADDR_CONTROL, 8'h12}, 6, FRAME_BITS - 1);
		repeat (20) @(posedge clk_sys);
		check_state();
		$display("cut frame test done");
		// Power-down pin low clears everything without help from rst.
		@(posedge clk_sys) power_down_reset_pin_n <= 1'h0;
		repeat (2) @(posedge clk_sys);
		power_down_reset_pin_n <= 1'h1;
		{e1, e2} = 6'h00;
		repeat (4) @(posedge clk_sys);
		check_state();
		write(strap, WRITE_BIT, ADDR_CONTROL, 8'h71, 1);
		check_state();
		$display("power-down test done");
		finish_test();
	end
endmodule

// ---- logic/vis_regs.sv ----
// Control register bank of the two-output video input selector with three-wire write port.
`timescale 1ns/1ns
module vis_regs
	import vis_pkg::*;
(
	// Clock and reset.
	input  wire logic                   clk_sys,
	input  wire logic                   rst,
	input  wire logic                   power_down_reset_pin_n,
	// Three-wire serial write port.
	input  wire logic                   serial_select_n,
	input  wire logic                   serial_shift_clock,
	input  wire logic                   serial_data_input,
	// Chip address straps.
	input  wire logic                   chip_addr_bit_low,
	input  wire logic                   chip_addr_bit_high,
	// Register read-back.
	input  wire logic [4:0]             read_addr,
	output logic      [7:0]             read_data,
	// Selection state and switch drive.
	output logic      [2:0]             first_output_select,
	output logic      [2:0]             second_output_select,
	output logic      [INPUT_COUNT-1:0] video_out_first_enable,
	output logic      [INPUT_COUNT-1:0] video_out_second_enable,
	output logic                        write_accepted
);

	// -------------------------------------------------------------------
	// Elaboration checks.
	// -------------------------------------------------------------------
	if (SCLK_PERIOD_CYC < SAMPLES_MIN) begin : g_rate_check
		$error("System clock too slow to sample the serial clock.");
	end

	// -------------------------------------------------------------------
	// Reset and pin synchronisation.
	// -------------------------------------------------------------------
	logic          clear_async;
	logic [4:0]    pins_sync;
	logic          csn_s;
	logic          sclk_s;
	logic          sdi_s;
	logic [1:0]    strap_s;

	// Power-down clears the bank without waiting for a clock.
	assign clear_async = rst | ~power_down_reset_pin_n;

	vis_sync #(
		.WIDTH     (5),
		.RESET_VAL (5'h10)
	) u_sync (
		.clk_sys  (clk_sys),
		.rst      (clear_async),
		.pin_in   ({serial_select_n, serial_shift_clock, serial_data_input,
			chip_addr_bit_high, chip_addr_bit_low}),
		.sync_out (pins_sync)
	);

	// Named views of the synchronised pins.
	assign csn_s   = pins_sync[4];
	assign sclk_s  = pins_sync[3];
	assign sdi_s   = pins_sync[2];
	assign strap_s = pins_sync[1:0];

	// -------------------------------------------------------------------
	// Frame receiver.
	// -------------------------------------------------------------------
	logic          sclk_prev_reg;
	logic          csn_prev_reg;
	vis_state_type state_reg;
	vis_state_type state_next;
	logic [4:0]    count_reg;
	logic [4:0]    count_next;
	logic [15:0]   shift_reg;
	logic [15:0]   shift_next;
	logic          sclk_rise;
	logic          csn_fall;
	logic          last_edge;
	vis_frame_type frame;
	logic          frame_ok;
	logic          write_fire;

	// Edges are taken from the synchronised copies only.
	assign sclk_rise  = sclk_s & ~sclk_prev_reg;
	assign csn_fall   = ~csn_s & csn_prev_reg;
	assign last_edge  = (state_reg == VIS_SHIFT) && sclk_rise && !csn_s
		&& (count_reg == 5'(FRAME_BITS - 1));
	assign frame      = vis_frame_type'({shift_reg[14:0], sdi_s});
	// Only a write to this chip at the control address lands.
	assign frame_ok   = (frame.chip_addr == strap_s) && (frame.write_bit == WRITE_BIT)
		&& (frame.reg_addr == ADDR_CONTROL);
	assign write_fire = last_edge && frame_ok;

	// Next-state logic: shift MSB first, stop after sixteen bits until deselect.
	always_comb begin
		state_next = state_reg;
		count_next = count_reg;
		shift_next = shift_reg;
		case (state_reg)
			VIS_IDLE: begin
				if (csn_fall) begin
					state_next = VIS_SHIFT;
					count_next = 5'h00;
				end
			end
			VIS_SHIFT: begin
				if (csn_s) begin
					state_next = VIS_IDLE;
				end else if (sclk_rise) begin
					shift_next = {shift_reg[14:0], sdi_s};
					count_next = count_reg + 5'h01;
					if (last_edge) begin
						state_next = VIS_WAIT_DESELECT;
					end
				end
			end
			VIS_WAIT_DESELECT: begin
				if (csn_s) begin
					state_next = VIS_IDLE;
				end
			end
			default: begin
				state_next = VIS_IDLE;
			end
		endcase
	end

	// Receiver state flops.
	always_ff @(posedge clk_sys or posedge clear_async) begin
		if (clear_async) begin
			state_reg     <= VIS_IDLE;
			count_reg     <= 5'h00;
			shift_reg     <= 16'h0000;
			sclk_prev_reg <= 1'b0;
			csn_prev_reg  <= 1'b1;
		end else begin
			state_reg     <= state_next;
			count_reg     <= count_next;
			shift_reg     <= shift_next;
			sclk_prev_reg <= sclk_s;
			csn_prev_reg  <= csn_s;
		end
	end

	// -------------------------------------------------------------------
	// Control register and outputs.
	// -------------------------------------------------------------------
	vis_ctrl_type ctrl_reg;
	vis_ctrl_type ctrl_next;
	logic [7:0]   read_next;

	// Only the two fields are stored, so fixed-zero bits cannot be set.
	assign ctrl_next.first_sel  = write_fire ? frame.data[FIRST_SEL_LSB +: SEL_W]
		: ctrl_reg.first_sel;
	assign ctrl_next.second_sel = write_fire ? frame.data[SECOND_SEL_LSB +: SEL_W]
		: ctrl_reg.second_sel;
	// The reserved address and unmapped addresses read as zero.
	assign read_next = (read_addr == ADDR_CONTROL) ? vis_ctrl_image(ctrl_reg)
		: RESERVED_READ;

	// Register bank; reset leaves both outputs grounded.
	always_ff @(posedge clk_sys or posedge clear_async) begin
		if (clear_async) begin
			ctrl_reg <= vis_ctrl_type'({CTRL_RESET[6:4], CTRL_RESET[2:0]});
		end else begin
			ctrl_reg <= ctrl_next;
		end
	end

	// Registered read-back, decoded switch drive and write pulse.
	always_ff @(posedge clk_sys or posedge clear_async) begin
		if (clear_async) begin
			read_data               <= RESERVED_READ;
			video_out_first_enable  <= '0;
			video_out_second_enable <= '0;
			write_accepted          <= 1'b0;
		end else begin
			read_data               <= read_next;
			video_out_first_enable  <= vis_input_enables(ctrl_reg.first_sel);
			video_out_second_enable <= vis_input_enables(ctrl_reg.second_sel);
			write_accepted          <= write_fire;
		end
	end

	assign first_output_select  = ctrl_reg.first_sel;
	assign second_output_select = ctrl_reg.second_sel;

	// -------------------------------------------------------------------
	// Assertions and covers.
	// -------------------------------------------------------------------
	first_field_load_a: assert property (@(posedge clk_sys) disable iff (clear_async)
		write_fire |=> first_output_select == $past(frame.data[2:0]))
		else $error("First select field did not load bits 2:0.");

	second_field_load_a: assert property (@(posedge clk_sys) disable iff (clear_async)
		write_fire |=> second_output_select == $past(frame.data[6:4]))
		else $error("Second select field did not load bits 6:4.");

	first_reset_off_a: assert property (@(posedge clk_sys)
		rst |-> first_output_select == 3'h0 && video_out_first_enable == '0)
		else $error("First output not grounded during reset.");

	second_reset_off_a: assert property (@(posedge clk_sys)
		rst |-> second_output_select == 3'h0 && video_out_second_enable == '0)
		else $error("Second output not grounded during reset.");

	pdn_clear_a: assert property (@(posedge clk_sys) disable iff (rst)
		!power_down_reset_pin_n |-> ctrl_reg == '0 && read_data == 8'h00)
		else $error("Power-down did not clear the registers.");

	// Enables lag the select by one cycle, so only a select held for two edges is compared.
	decode_map_a: assert property (@(posedge clk_sys) disable iff (clear_async)
		$stable(first_output_select) |-> video_out_first_enable == ((first_output_select == 3'h0)
		? 7'h00 : 7'(7'h01 << (first_output_select - 3'h1))))
		else $error("First output decode wrong.");

	second_decode_a: assert property (@(posedge clk_sys) disable iff (clear_async)
		$stable(second_output_select) |-> video_out_second_enable == ((second_output_select == 3'h0)
		? 7'h00 : 7'(7'h01 << (second_output_select - 3'h1))))
		else $error("Second output decode wrong.");

	sixteenth_edge_a: assert property (@(posedge clk_sys) disable iff (clear_async)
		(state_reg == VIS_SHIFT && count_reg < 5'(FRAME_BITS - 1)) |=> $stable(ctrl_reg))
		else $error("Control register changed before the sixteenth edge.");

	pulse_follows_a: assert property (@(posedge clk_sys) disable iff (clear_async)
		write_accepted |-> $past(last_edge) && $past(frame.reg_addr) == ADDR_CONTROL
		&& state_reg == VIS_WAIT_DESELECT)
		else $error("Write pulse without a matching frame.");

	cover_write_c:    cover property (@(posedge clk_sys) disable iff (clear_async)
		write_fire ##1 write_accepted);
	cover_foreign_c:  cover property (@(posedge clk_sys) disable iff (clear_async)
		last_edge && !frame_ok);
	cover_pdn_c:      cover property (@(posedge clk_sys) disable iff (rst)
		$fell(power_down_reset_pin_n));
	cover_seventh_c:  cover property (@(posedge clk_sys) disable iff (clear_async)
		video_out_second_enable[6]);

endmodule

// ---- logic/vis_sync.sv ----
// Two-flip-flop synchroniser for pin inputs.
`timescale 1ns/1ns
module vis_sync
	import vis_pkg::*;
#(
	parameter int               WIDTH     = 1,
	parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
	// Clock and reset.
	input  wire logic             clk_sys,
	input  wire logic             rst,
	// Asynchronous pins in, synchronised levels out.
	input  wire logic [WIDTH-1:0] pin_in,
	output logic      [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] meta_reg;

	// The first stage feeds only the second stage.
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			meta_reg <= RESET_VAL;
			sync_out <= RESET_VAL;
		end else begin
			meta_reg <= pin_in;
			sync_out <= meta_reg;
		end
	end

endmodule
